// ---- test/scmc_checker.sv ----
/*
 Port assertions for scmc_channel_config: clock pin roles, length, sources.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module scmc_checker (
	input wire		sys_clk,
	input wire		resetn,
	input wire [3:0]	regAddr,
	input wire [7:0]	regWrData,
	input wire		regWrite,
	input wire		regRead,
	input wire [7:0]	regRdData,
	input wire		baudTick,
	input wire		timerMatchA,
	input wire		timerMatchB,
	input wire		serialClockOe,
	input wire		serialClockOut,
	input wire [3:0]	charLength,
	input wire		asyncClock,
	input wire		collisionTick
);
	reg [7:0]	sm, sk, sc, se, sp, sr;	// Shadows of mode, ctrl, card, ext, spi, cr2
	reg [2:0]	quiet;			// Cycles since the last write, saturating
	wire		asy = !sm[5] && !sc[0] && !sp[0];	// Asynchronous mode
	wire		ok = quiet > 3'h2;	// Outputs have caught up with the shadows

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Shadow writes; the skip bit is copied as written even though hardware clears it
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{sm, sk, se, sp, sr} <= 40'h0;
			sc <= 8'h10;
			quiet <= 3'h0;
		end else begin
			quiet <= regWrite ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
			if (regWrite)
				case (regAddr)
					4'h0: sm <= regWrData;
					4'h1: sk <= regWrData;
					4'h2: sc <= regWrData;
					4'h3: se <= regWrData;
					4'h4: sp <= regWrData;
					4'h5: sr <= regWrData;
					default: ;
				endcase
		end
	end

	len_map_a: assert property (
		ok && asy |-> charLength == (sc[4] ? (sm[6] ? 4'h7 : 4'h8) : 4'h9))
		else $error("char length wrong");
	async_float_a: assert property (
		ok && asy && sk[1:0] == 2'h0 |-> !serialClockOe) else $error("clock pin driven");
	bitclk_out_a: assert property (
		ok && asy && sk[1:0] == 2'h1 |-> serialClockOe) else $error("clock pin not driven");
	timer_float_a: assert property (
		ok && asy && sk[1] && se[0] |-> !serialClockOe) else $error("timer source drives pin");
	timer_and_a: assert property (
		ok && asy && sk[1] && se[0] |=> asyncClock == $past(timerMatchA && timerMatchB))
		else $error("timer clock wrong");
	sync_pin_a: assert property (
		ok && sm[5] && !sc[0] && !sp[0] |-> serialClockOe == !sk[1]) else $error("sync pin role");
	card_fixed_a: assert property (
		ok && sc[0] && sm[7] && !sk[0] |-> serialClockOe && serialClockOut == sk[1])
		else $error("card fixed level wrong");
	card_off_a: assert property (
		ok && sc[0] && !sm[7] && sk[1:0] == 2'h0 |-> !serialClockOe) else $error("card clock on");
	coll_half_a: assert property (
		quiet == 3'h7 && !se[6] && sr[5:4] == 2'h1 && collisionTick |=> !collisionTick ##1
		collisionTick) else $error("collision tick spacing");
	clk_rate_a: assert property (
		ok && asy && sk[1:0] == 2'h1 |->
		(serialClockOut ^ $past(serialClockOut)) == $past(baudTick, 2))
		else $error("clock pin rate wrong");
	rd_idle_a: assert property (
		regRdData != 8'h00 |-> $past(regRead)) else $error("read data outside slot");
endmodule // scmc_checker

bind scmc_channel_config scmc_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
	.regRdData(regRdData), .timerMatchA(timerMatchA), .timerMatchB(timerMatchB),
	.serialClockOe(serialClockOe), .serialClockOut(serialClockOut), .baudTick(baudTick),
	.charLength(charLength), .asyncClock(asyncClock), .collisionTick(collisionTick));

// ---- test/scmc_remote.sv ----
/*
 Remote serial device on the clock and two SPI data pins.
 Assumes enables from the channel; resolves each wire from both parties.
*/
`timescale 1ns/1ns
module scmc_remote #(
	parameter HALF = 2	// Cycles per half period of the external clock
) (
	input wire	sys_clk,
	input wire	outOe,
	input wire	outDrv,
	input wire	inOe,
	input wire	inDrv,
	input wire	clkOe,
	input wire	clkDrv,
	output wire	outPin,
	output wire	inPin,
	output wire	clkPin
);
	localparam [3:0] LAST = HALF - 1;
	reg [7:0]	pat = 8'h5a;	// Changes every cycle so a float never looks held
	reg [3:0]	cnt = 4'h0;
	reg		extClk = 1'b0;

	// external clock toggling every HALF cycles of sys_clk, free of the bit rate
	always @(posedge sys_clk) begin
		pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
		cnt <= (cnt == LAST) ? 4'h0 : cnt + 4'h1;
		if (cnt == LAST)
			extClk <= ~extClk;
	end

	// remote sends on whichever data pin the channel leaves
	assign outPin = outOe ? outDrv : pat[0];
	assign inPin = inOe ? inDrv : pat[1];
	assign clkPin = clkOe ? clkDrv : extClk;
endmodule // scmc_remote

// ---- test/testbench.sv ----
/*
 Self-checking bench for scmc_channel_config with a register model.
 Assumes scmc_remote on the pins and the checker bound in.
*/
`timescale 1ns/1ns
`include "scmc_defs.vh"
module testbench;
	reg		sys_clk, resetn, regWrite, regRead, baudTick, txBit;
	reg		timerMatchA, timerMatchB, frameDone, frameMpBit, frameOverrun, frameFramingErr;
	reg [3:0]	regAddr;
	reg [7:0]	regWrData;
	reg [31:0]	seed;
	reg [7:0]	mdl [0:7];	// Register model; index 6 is status
	integer		miscompares, num_checks, i, cnt;
	wire [7:0]	regRdData;
	wire [3:0]	charLength;
	wire [4:0]	extClockRatio;
	wire		serialClockIn, serialClockOut, serialClockOe, masterOutIn, masterOutOut;
	wire		masterOutOe, masterInIn, masterInOut, masterInOe, rxBit;
	wire		useExternalClock, asyncClock, collisionTick, irq;
	wire		asyncMode = !mdl[0][5] && !mdl[2][0] && !mdl[4][0];
	localparam [47:0] RST = 48'h0000_0010_0000;	// Reset bytes, offset 0 lowest
	localparam [47:0] MSK = 48'h3005_5111_0be7;	// Implemented bits, offset 0 lowest

	scmc_channel_config #(.ID_CODE(8'h3c)) u_scmc_channel_config (.sys_clk(sys_clk),
		.resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .baudTick(baudTick),
		.timerMatchA(timerMatchA), .timerMatchB(timerMatchB), .serialClockIn(serialClockIn),
		.serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
		.masterOutIn(masterOutIn), .masterOutOut(masterOutOut), .masterOutOe(masterOutOe),
		.masterInIn(masterInIn), .masterInOut(masterInOut), .masterInOe(masterInOe),
		.txBit(txBit), .rxBit(rxBit), .frameDone(frameDone), .frameMpBit(frameMpBit),
		.frameOverrun(frameOverrun), .frameFramingErr(frameFramingErr),
		.charLength(charLength), .useExternalClock(useExternalClock),
		.extClockRatio(extClockRatio), .asyncClock(asyncClock),
		.collisionTick(collisionTick), .irq(irq));
	scmc_remote #(.HALF(2)) u_scmc_remote (.sys_clk(sys_clk), .outOe(masterOutOe),
		.outDrv(masterOutOut), .inOe(masterInOe), .inDrv(masterInOut),
		.clkOe(serialClockOe), .clkDrv(serialClockOut), .outPin(masterOutIn),
		.inPin(masterInIn), .clkPin(serialClockIn));

	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction

	// Source and result of each pass-through path, with the pin enable
	function [2:0] pick(input [1:0] s, input o);
		case (s)
			2'h0: pick = o ? {2'h0, asyncClock} : {2'h0, serialClockIn};
			2'h1: pick = o ? {2'h0, asyncClock} : {2'h0, timerMatchA & timerMatchB};
			2'h2: pick = o ? {masterOutOe, masterOutOut, rxBit} : {1'b1, txBit, masterInIn};
			default: pick = o ? {masterInOe, masterInOut, rxBit} : {1'b1, txBit, masterOutIn};
		endcase
	endfunction

	task chk(input [7:0] g, input [7:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("BAD %0t got %h exp %h", $time, g, e);
			end
		end
	endtask

	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge sys_clk);
			regAddr <= a;
			regWrData <= d;
			regWrite <= 1'b1;
			@(posedge sys_clk);
			regWrite <= 1'b0;
			if (a == `SCMC_ADDR_STATUS)
				mdl[6] = mdl[6] & ~d;
			else if (a < 4'h8)
				mdl[a] = d;
		end
	endtask

	task rd(input [3:0] a, input [7:0] m, input [7:0] e);
		begin
			@(posedge sys_clk);
			regAddr <= a;
			regRead <= 1'b1;
			@(posedge sys_clk);
			regRead <= 1'b0;
			#1 chk(regRdData & m, e & m);
		end
	endtask

	task settle;
		begin
			repeat (3) @(posedge sys_clk);
			#1;
		end
	endtask

	task irqChk;
		begin
			settle;
			chk({7'h0, irq}, {7'h0, |(mdl[6] & mdl[7])});
		end
	endtask

	task frame(input mp, input ov, input fe);
		begin
			@(posedge sys_clk);
			frameDone <= 1'b1;
			frameMpBit <= mp;
			frameOverrun <= ov;
			frameFramingErr <= fe;
			@(posedge sys_clk);
			frameDone <= 1'b0;
			if (asyncMode && mdl[0][2] && mdl[1][3]) begin
				if (mp) begin
					mdl[6] = mdl[6] | 8'h09 | {5'h0, fe, ov, 1'b0};
					mdl[1][3] = 1'b0;
				end
			end else
				mdl[6] = mdl[6] | {5'h0, fe, ov, 1'b1};
		end
	endtask

	task pinCase(input [7:0] m, input [7:0] c, input [7:0] k, input [7:0] e, input [1:0] x);
		begin
			wr(`SCMC_ADDR_MODE, m);
			wr(`SCMC_ADDR_CTRL, c);
			wr(`SCMC_ADDR_CARD, k);
			wr(`SCMC_ADDR_EXT, e);
			settle;
			chk({7'h0, serialClockOe}, {7'h0, x != 2'h0});
			if (x[1])
				chk({7'h0, serialClockOut}, {7'h0, x[0]});
		end
	endtask

	task follow(input [1:0] s);
		reg [2:0] v;
		begin
			settle;
			@(negedge sys_clk) v = pick(s, 1'b0);
			repeat (8) begin
				@(negedge sys_clk);
				chk({5'h0, pick(s, 1'b1)}, {5'h0, v});
				v = pick(s, 1'b0);
			end
		end
	endtask

	task coll(input [7:0] e, input [7:0] m, input [7:0] c, input [7:0] n);
		begin
			wr(`SCMC_ADDR_EXT, e);
			wr(`SCMC_ADDR_MODE, m);
			wr(`SCMC_ADDR_CR2, c);
			settle;
			cnt = 0;
			repeat (16) begin
				@(posedge sys_clk);
				#1 cnt = cnt + collisionTick;
			end
			chk(cnt[7:0], n);
		end
	endtask

	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// Random engine-side inputs, fresh every cycle
	always @(posedge sys_clk) begin
		seed = xs(seed);
		baudTick <= seed[0];
		txBit <= seed[1];
		timerMatchA <= seed[2] | seed[3];
		timerMatchB <= seed[4] | seed[5];
	end

	// Hang guard, far beyond the run length
	initial begin
		#400000;
		miscompares = miscompares + 1;
		tally_and_finish;
	end

	initial begin
		{regWrite, regRead, baudTick, txBit, timerMatchA, timerMatchB} = 6'h0;
		{frameDone, frameMpBit, frameOverrun, frameFramingErr} = 4'h0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		resetn = 1'b0;
		seed = 32'h0d23_be1c;
		miscompares = 0;
		num_checks = 0;
		for (i = 0; i < 8; i = i + 1)
			mdl[i] = (i < 6) ? RST[8*i +: 8] : 8'h00;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		// Reset values, unmapped place, identity value
		for (i = 0; i < 8; i = i + 1)
			rd(i[3:0], 8'hff, mdl[i]);
		rd(4'hc, 8'hff, 8'h00);
		rd(`SCMC_ADDR_INFO, 8'hff, 8'h3c);
		for (i = 0; i < 6; i = i + 1) begin
			wr(i[3:0], seed[15:8]);
			rd(i[3:0], MSK[8*i +: 8], mdl[i]);
		end
		for (i = 0; i < 6; i = i + 1)
			wr(i[3:0], RST[8*i +: 8]);
		for (i = 0; i < 4; i = i + 1) begin
			wr(`SCMC_ADDR_CARD, {3'h0, i[1], 4'h0});
			wr(`SCMC_ADDR_MODE, {1'b0, i[0], 6'h0});
			settle;
			chk({4'h0, charLength}, (i < 2) ? 8'h09 : (i == 2) ? 8'h08 : 8'h07);
		end
		pinCase(8'h00, 8'h00, 8'h10, 8'h00, 2'h0);
		pinCase(8'h00, 8'h01, 8'h10, 8'h00, 2'h1);
		chk({7'h0, useExternalClock}, 8'h00);
		pinCase(8'h00, 8'h02, 8'h10, 8'h01, 2'h0);
		pinCase(8'h20, 8'h01, 8'h10, 8'h00, 2'h1);
		pinCase(8'h20, 8'h02, 8'h10, 8'h00, 2'h0);
		follow(2'h0);
		pinCase(8'h00, 8'h00, 8'h01, 8'h00, 2'h0);
		pinCase(8'h00, 8'h01, 8'h01, 8'h00, 2'h1);
		pinCase(8'h80, 8'h00, 8'h01, 8'h00, 2'h2);
		pinCase(8'h80, 8'h03, 8'h01, 8'h00, 2'h1);
		pinCase(8'h80, 8'h02, 8'h01, 8'h00, 2'h3);
		pinCase(8'h00, 8'h02, 8'h10, 8'h00, 2'h0);
		chk({3'h0, extClockRatio}, 8'h10);
		chk({7'h0, useExternalClock}, 8'h01);
		follow(2'h0);
		wr(`SCMC_ADDR_EXT, 8'h10);
		settle;
		chk({3'h0, extClockRatio}, 8'h08);
		wr(`SCMC_ADDR_EXT, 8'h01);
		follow(2'h1);
		// Multiprocessor skip, status flags and interrupt
		wr(`SCMC_ADDR_MODE, 8'h04);
		wr(`SCMC_ADDR_CTRL, 8'h08);
		wr(`SCMC_ADDR_MASK, 8'h0f);
		frame(1'b0, 1'b1, 1'b1);
		rd(`SCMC_ADDR_STATUS, 8'hff, mdl[6]);
		irqChk;
		frame(1'b1, 1'b0, 1'b0);
		rd(`SCMC_ADDR_STATUS, 8'hff, mdl[6]);
		rd(`SCMC_ADDR_CTRL, 8'h08, mdl[1]);
		frame(1'b0, 1'b1, 1'b1);
		rd(`SCMC_ADDR_STATUS, 8'hff, mdl[6]);
		irqChk;
		wr(`SCMC_ADDR_MASK, 8'h00);
		irqChk;
		wr(`SCMC_ADDR_MASK, 8'h0f);
		wr(`SCMC_ADDR_STATUS, 8'h0f);
		irqChk;
		rd(`SCMC_ADDR_STATUS, 8'hff, mdl[6]);
		coll(8'h00, 8'h00, 8'h10, 8'h08);
		coll(8'h00, 8'h00, 8'h20, 8'h04);
		coll(8'h40, 8'h01, 8'h10, 8'h08);
		coll(8'h40, 8'h00, 8'h00, 8'h08);
		coll(8'h40, 8'h00, 8'h10, 8'h04);
		wr(`SCMC_ADDR_MODE, 8'h20);
		wr(`SCMC_ADDR_SPI, 8'h01);
		follow(2'h2);
		wr(`SCMC_ADDR_SPI, 8'h05);
		follow(2'h3);
		tally_and_finish;
	end
endmodule // testbench

// ---- verilog/scmc_channel_config.v ----
/*
 Mode configuration of a multi-mode serial channel: character length, clock
 source and clock pin role, multiprocessor receive skip, simple SPI pin roles
 and the bus collision detection clock divider. Holds the mode registers and
 an interrupt status/mask pair.
 Assumes pins are synchronous to sys_clk, a baud tick from a baud generator,
 and a receive engine that reports each finished frame with one pulse.
*/
// The plain strobed port and the placing of the registers were decided locally.
//
// Notes on behaviour
// RL1 - Length from extended bit and length bit
// RL2 - Async select 00: internal, clock pin floats
// RL3 - Async select 01: output bit-rate clock
// RL4 - External async clock is sixteen times bit rate
// RL5 - Basic clock select: external clock eight times
// RL6 - Timer clock source: clock pin floats
// RL7 - Sync mode: 0x outputs clock, 1x inputs
// RL8 - Skip frames with multiprocessor bit zero
// RL9 - Wake frame clears skip enable automatically
// RL10 - Card mode, block off: 00 off, 01 clock
// RL11 - Card block mode: 00 low, x1 clock, 10 high
// RL12 - Source select: external or timer AND
// RL13 - SPI master: send master-out, receive master-in
// RL14 - SPI slave: receive master-out, send master-in
// RL15 - Collision clock 01 by two, 10 by four
// RL16 - Double speed prescaler 00: 00 by two, 01 by four
`timescale 1ns/1ns
`include "scmc_defs.vh"
module scmc_channel_config #(
	parameter ID_CODE = 8'h5A   // Arbitrary identification value
) (
	input  wire       sys_clk,
	input  wire       resetn,
	input  wire [3:0] regAddr,
	input  wire [7:0] regWrData,
	input  wire       regWrite,
	input  wire       regRead,
	output reg  [7:0] regRdData,
	input  wire       baudTick,
	input  wire       timerMatchA,
	input  wire       timerMatchB,
	input  wire       serialClockIn,
	output reg        serialClockOut,
	output reg        serialClockOe,
	input  wire       masterOutIn,
	output reg        masterOutOut,
	output reg        masterOutOe,
	input  wire       masterInIn,
	output reg        masterInOut,
	output reg        masterInOe,
	input  wire       txBit,
	output reg        rxBit,
	input  wire       frameDone,
	input  wire       frameMpBit,
	input  wire       frameOverrun,
	input  wire       frameFramingErr,
	output reg  [3:0] charLength,
	output reg        useExternalClock,
	output reg  [4:0] extClockRatio,
	output reg        asyncClock,
	output reg        collisionTick,
	output reg        irq
);
	reg [7:0] serialModeReg;          // Mode: prescaler, multiproc, length
	reg [7:0] serialControlReg;       // Clock select and skip enable
	reg [7:0] smartCardModeReg;       // Card select and extended length
	reg [7:0] serialExtendedModeReg;  // Clock source and double speed
	reg [7:0] simpleSpiModeReg;       // SPI enable and master-slave select
	reg [7:0] extSerialControlReg2;   // Collision clock select
	reg [3:0] irqMask;                // Interrupt mask, same layout as status
	reg       bitClock;               // Bit-rate clock toggled on baud ticks
	reg [7:0] next_collisionDiv;      // Divide value for collision clock
	reg       acceptFrame;            // Frame passes the skip filter
	reg       wakeFrame;              // Frame ends a skip
	wire [3:0] irqStatus;             // Sticky event bits
	wire [3:0] clearBits;             // Write-one-to-clear strobes
	wire       divTick;               // Collision divider tick

	// Field views
	wire [1:0] clockSelect  = serialControlReg[`SCMC_CTRL_CKE_LO+1:`SCMC_CTRL_CKE_LO];
	wire [1:0] prescaler    = serialModeReg[`SCMC_MODE_CKS_LO+1:`SCMC_MODE_CKS_LO];
	wire [1:0] collisionSel = extSerialControlReg2[`SCMC_CR2_BCCS_LO+1:`SCMC_CR2_BCCS_LO];
	wire cardMode    = smartCardModeReg[`SCMC_CARD_SMART_CARD_SELECT];
	wire syncMode    = serialModeReg[`SCMC_MODE_CM] & ~cardMode;
	wire asyncMode   = ~serialModeReg[`SCMC_MODE_CM] & ~cardMode;
	wire blockMode   = serialModeReg[`SCMC_MODE_GM];
	wire mpMode      = serialModeReg[`SCMC_MODE_MP];
	wire skipEnable  = serialControlReg[`SCMC_CTRL_MULTIPROC_SKIP_ENABLE];
	wire spiMode     = simpleSpiModeReg[`SCMC_SPI_EN];
	wire slaveSelect = simpleSpiModeReg[`SCMC_SPI_MSS];
	wire timerSource = serialExtendedModeReg[`SCMC_EXT_ASYNC_CLOCK_SOURCE_SELECT];
	wire doubleSpeed = serialExtendedModeReg[`SCMC_EXT_DOUBLE_SPEED_SELECT];

	// Skip filter on finished frames
	always @* begin
		acceptFrame = frameDone;
		wakeFrame   = 1'b0;
		if (asyncMode && mpMode && skipEnable) begin
			// RL8 drop idle frames
			// Flags stay untouched for skipped frames
			acceptFrame = frameDone & frameMpBit;
			// RL9 detect wake frame
			wakeFrame   = frameDone & frameMpBit;
		end
	end

	assign clearBits = (regWrite && regAddr == `SCMC_ADDR_STATUS) ? regWrData[3:0] : 4'h0;

	// One sticky bit per event
	scmc_sticky uStRx (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.setEvent    (acceptFrame),
		.clearStrobe (clearBits[`SCMC_ST_RXFULL]),
		.flag        (irqStatus[`SCMC_ST_RXFULL])
	);
	scmc_sticky uStOv (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.setEvent    (acceptFrame & frameOverrun),
		.clearStrobe (clearBits[`SCMC_ST_OVERRUN]),
		.flag        (irqStatus[`SCMC_ST_OVERRUN])
	);
	scmc_sticky uStFe (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.setEvent    (acceptFrame & frameFramingErr),
		.clearStrobe (clearBits[`SCMC_ST_FRAMING]),
		.flag        (irqStatus[`SCMC_ST_FRAMING])
	);
	scmc_sticky uStWk (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.setEvent    (wakeFrame),
		.clearStrobe (clearBits[`SCMC_ST_MPWAKE]),
		.flag        (irqStatus[`SCMC_ST_MPWAKE])
	);

	// Register writes; the skip enable also clears itself on a wake frame
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			serialModeReg         <= `SCMC_RST_MODE;
			serialControlReg      <= `SCMC_RST_CTRL;
			smartCardModeReg      <= `SCMC_RST_CARD;
			serialExtendedModeReg <= `SCMC_RST_EXT;
			simpleSpiModeReg      <= `SCMC_RST_SPI;
			extSerialControlReg2  <= `SCMC_RST_CR2;
			irqMask               <= 4'h0;
		end else begin
			if (regWrite) begin
				if (regAddr == `SCMC_ADDR_MODE) begin
					serialModeReg <= regWrData;
				end else if (regAddr == `SCMC_ADDR_CTRL) begin
					serialControlReg <= regWrData;
				end else if (regAddr == `SCMC_ADDR_CARD) begin
					smartCardModeReg <= regWrData;
				end else if (regAddr == `SCMC_ADDR_EXT) begin
					serialExtendedModeReg <= regWrData;
				end else if (regAddr == `SCMC_ADDR_SPI) begin
					simpleSpiModeReg <= regWrData;
				end else if (regAddr == `SCMC_ADDR_CR2) begin
					extSerialControlReg2 <= regWrData;
				end else if (regAddr == `SCMC_ADDR_MASK) begin
					irqMask <= regWrData[3:0];
				end
			end
			// RL9 hardware clear
			// Hardware clear beats a same-cycle software write of the bit
			if (wakeFrame) begin
				serialControlReg[`SCMC_CTRL_MULTIPROC_SKIP_ENABLE] <= 1'b0;
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			if (regAddr == `SCMC_ADDR_MODE) begin
				regRdData <= serialModeReg;
			end else if (regAddr == `SCMC_ADDR_CTRL) begin
				regRdData <= serialControlReg;
			end else if (regAddr == `SCMC_ADDR_CARD) begin
				regRdData <= smartCardModeReg;
			end else if (regAddr == `SCMC_ADDR_EXT) begin
				regRdData <= serialExtendedModeReg;
			end else if (regAddr == `SCMC_ADDR_SPI) begin
				regRdData <= simpleSpiModeReg;
			end else if (regAddr == `SCMC_ADDR_CR2) begin
				regRdData <= extSerialControlReg2;
			end else if (regAddr == `SCMC_ADDR_STATUS) begin
				regRdData <= {4'h0, irqStatus};
			end else if (regAddr == `SCMC_ADDR_MASK) begin
				regRdData <= {4'h0, irqMask};
			end else if (regAddr == `SCMC_ADDR_INFO) begin
				regRdData <= ID_CODE;
			end else begin
				regRdData <= 8'h00;
			end
		end else begin
			regRdData <= 8'h00;
		end
	end

	// Level interrupt from unmasked sticky bits
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

	// Bit-rate clock: one baud tick per half period
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bitClock <= 1'b0;
		end else if (baudTick) begin
			bitClock <= ~bitClock;
		end
	end

	// Character length and external clock ratio
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			charLength    <= `SCMC_LEN8;
			extClockRatio <= 5'h10;
		end else begin
			// RL1 length decode
			// Synchronous and card modes are fixed at eight bits
			if (!asyncMode) begin
				charLength <= `SCMC_LEN8;
			end else if (!smartCardModeReg[`SCMC_CARD_CHAR_LENGTH_EXT_BIT]) begin
				charLength <= `SCMC_LEN9;
			end else if (serialModeReg[`SCMC_MODE_CHR]) begin
				charLength <= `SCMC_LEN7;
			end else begin
				charLength <= `SCMC_LEN8;
			end
			// RL4 sixteen times
			// RL5 eight times with basic clock select
			if (serialExtendedModeReg[`SCMC_EXT_ASYNC_BASIC_CLOCK_SELECT]) begin
				extClockRatio <= 5'h08;
			end else begin
				extClockRatio <= 5'h10;
			end
		end
	end

	// Clock source and clock pin role
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			serialClockOut   <= 1'b0;
			serialClockOe    <= 1'b0;
			useExternalClock <= 1'b0;
			asyncClock       <= 1'b0;
		end else begin
			serialClockOut   <= 1'b0;
			serialClockOe    <= 1'b0;
			useExternalClock <= 1'b0;
			asyncClock       <= bitClock;
			if (cardMode) begin
				if (!blockMode) begin
					// RL10 card clock off or on; 1x treated as off
					serialClockOe  <= (clockSelect == 2'b01);
					serialClockOut <= bitClock;
				end else begin
					// RL11 fixed levels or clock
					serialClockOe <= 1'b1;
					if (clockSelect[0]) begin
						serialClockOut <= bitClock;
					end else begin
						serialClockOut <= clockSelect[1];
					end
				end
			end else if (syncMode) begin
				// RL7 internal out, external in
				if (!clockSelect[1]) begin
					serialClockOe  <= 1'b1;
					serialClockOut <= bitClock;
				end else begin
					useExternalClock <= 1'b1;
					asyncClock       <= serialClockIn;
				end
			end else if (clockSelect == 2'b01) begin
				// RL3 bit-rate clock out
				serialClockOe  <= 1'b1;
				serialClockOut <= bitClock;
			end else if (clockSelect[1]) begin
				useExternalClock <= 1'b1;
				// RL12 source select
				// RL6 timer source leaves pin floating
				if (timerSource) begin
					asyncClock <= timerMatchA & timerMatchB;
				end else begin
					asyncClock <= serialClockIn;
				end
			end
			// RL2 select 00 keeps pin floating by default above
		end
	end

	// Simple SPI pin roles; outside SPI the data pins rest undriven
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			masterOutOut <= 1'b1;
			masterOutOe  <= 1'b0;
			masterInOut  <= 1'b1;
			masterInOe   <= 1'b0;
			rxBit        <= 1'b1;
		end else if (spiMode && !slaveSelect) begin
			// RL13 master roles
			masterOutOut <= txBit;
			masterOutOe  <= 1'b1;
			masterInOut  <= 1'b1;
			masterInOe   <= 1'b0;
			rxBit        <= masterInIn;
		end else if (spiMode) begin
			// RL14 slave roles
			masterOutOut <= 1'b1;
			masterOutOe  <= 1'b0;
			masterInOut  <= txBit;
			masterInOe   <= 1'b1;
			rxBit        <= masterOutIn;
		end else begin
			masterOutOut <= 1'b1;
			masterOutOe  <= 1'b0;
			masterInOut  <= 1'b1;
			masterInOe   <= 1'b0;
			rxBit        <= masterInIn;
		end
	end

	// Collision clock divide value; prohibited codes fall back to four
	always @* begin
		if (doubleSpeed && prescaler == 2'b00) begin
			// RL16 shifted code table
			if (collisionSel == 2'b00) begin
				next_collisionDiv = 8'h02;
			end else begin
				next_collisionDiv = 8'h04;
			end
		end else begin
			// RL15 normal table; 00 passes the base clock
			if (collisionSel == 2'b00) begin
				next_collisionDiv = 8'h01;
			end else if (collisionSel == 2'b01) begin
				next_collisionDiv = 8'h02;
			end else begin
				next_collisionDiv = 8'h04;
			end
		end
	end

	scmc_divider #(
		.WIDTH (8)
	) uCollDiv (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.divValue (next_collisionDiv),
		.tick     (divTick)
	);

	// Register the collision tick as a data output
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			collisionTick <= 1'b0;
		end else begin
			collisionTick <= divTick;
		end
	end
endmodule // scmc_channel_config

// ---- verilog/scmc_defs.vh ----
/*
 Constants for the serial channel mode configuration block: register offsets,
 field positions, reset values and mode codes.
 Assumes it is included by bare name from the design files of this block.
*/
`ifndef SCMC_DEFS_VH
`define SCMC_DEFS_VH

// Register offsets on the plain register port
`define SCMC_ADDR_MODE      4'h0
`define SCMC_ADDR_CTRL      4'h1
`define SCMC_ADDR_CARD      4'h2
`define SCMC_ADDR_EXT       4'h3
`define SCMC_ADDR_SPI       4'h4
`define SCMC_ADDR_CR2       4'h5
`define SCMC_ADDR_STATUS    4'h6
`define SCMC_ADDR_MASK      4'h7
`define SCMC_ADDR_INFO      4'h8

// Reset values
`define SCMC_RST_MODE       8'h00
`define SCMC_RST_CTRL       8'h00
`define SCMC_RST_CARD       8'h10
`define SCMC_RST_EXT        8'h00
`define SCMC_RST_SPI        8'h00
`define SCMC_RST_CR2        8'h00

// serial_mode_reg fields
`define SCMC_MODE_CKS_LO    0
`define SCMC_MODE_MP        2
`define SCMC_MODE_CHR       6
`define SCMC_MODE_GM        7
`define SCMC_MODE_CM        5

// serial_control_reg fields
`define SCMC_CTRL_CKE_LO    0
`define SCMC_CTRL_MULTIPROC_SKIP_ENABLE      3

// smart_card_mode_reg fields
`define SCMC_CARD_SMART_CARD_SELECT      0
`define SCMC_CARD_CHAR_LENGTH_EXT_BIT      4

// serial_extended_mode_reg fields
`define SCMC_EXT_ASYNC_CLOCK_SOURCE_SELECT       0
`define SCMC_EXT_ASYNC_BASIC_CLOCK_SELECT       4
`define SCMC_EXT_DOUBLE_SPEED_SELECT       6

// simple_spi_mode_reg fields
`define SCMC_SPI_MSS        2
`define SCMC_SPI_EN         0

// ext_serial_control_reg2 fields
`define SCMC_CR2_BCCS_LO    4

// Status bits
`define SCMC_ST_RXFULL      0
`define SCMC_ST_OVERRUN     1
`define SCMC_ST_FRAMING     2
`define SCMC_ST_MPWAKE      3

// Character lengths
`define SCMC_LEN9           4'h9
`define SCMC_LEN8           4'h8
`define SCMC_LEN7           4'h7

`endif

// ---- verilog/scmc_divider.v ----
/*
 Divider that makes a one-cycle tick every DIV cycles of the system clock.
 Assumes a divide value of at least one.
*/
`timescale 1ns/1ns
module scmc_divider #(
	parameter WIDTH = 8
) (
	input  wire             sys_clk,
	input  wire             resetn,
	input  wire [WIDTH-1:0] divValue,
	output reg              tick
);
	reg [WIDTH-1:0] count;   // Cycles since last tick

	// Count up and tick at the wrap
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count <= {WIDTH{1'b0}};
			tick  <= 1'b0;
		end else if (count + {{(WIDTH-1){1'b0}}, 1'b1} >= divValue) begin
			// Wrap; a value of one ticks every cycle
			count <= {WIDTH{1'b0}};
			tick  <= 1'b1;
		end else begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
			tick  <= 1'b0;
		end
	end
endmodule // scmc_divider

// ---- verilog/scmc_sticky.v ----
/*
 One sticky status bit: set by a hardware event, cleared by writing one.
 Assumes the clear strobe is one cycle long.
*/
`timescale 1ns/1ns
module scmc_sticky (
	input  wire sys_clk,
	input  wire resetn,
	input  wire setEvent,
	input  wire clearStrobe,
	output reg  flag
);
	// Set wins over a clear in the same cycle so no event is lost
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flag <= 1'b0;
		end else if (setEvent) begin
			flag <= 1'b1;
		end else if (clearStrobe) begin
			flag <= 1'b0;
		end
	end
endmodule // scmc_sticky
